//--- mtpu_defs.vh
`ifndef MTPU_DEFS_VH
`define MTPU_DEFS_VH

// ****************************************
// Memory type encodings
// ****************************************
`define MTPU_TYPE_W 8
`define MTPU_UC 8'h00
`define MTPU_WC 8'h04
`define MTPU_WT 8'h05
`define MTPU_WP 8'h06
`define MTPU_WB 8'h07
`define MTPU_RESET_TYPE 8'h00

// ****************************************
// Line and chunk geometry
// ****************************************
`define MTPU_LINE_BYTES 32
`define MTPU_CHUNK_BYTES 8
`define MTPU_CHUNKS 4
`define MTPU_BE_FULL 32'hFFFFFFFF
`define MTPU_CHUNK_NONE 8'h00
`define MTPU_PINS_IDLE 4'hF

// ****************************************
// Bus sequencer states
// ****************************************
`define MTPU_S_IDLE 2'h0
`define MTPU_S_REQ1 2'h1
`define MTPU_S_REQ2 2'h2
`define MTPU_S_WAIT 2'h3

`endif

//--- mtpu_wcbuf.v
`timescale 1ns/1ps
`include "mtpu_defs.vh"

// ****************************************
// One-line combining buffer
// ****************************************
module mtpu_wcbuf #(
	parameter CHUNKS = `MTPU_CHUNKS
) (
	input wire clock,
	input wire rst_b,
	input wire wr_en,
	input wire [35:5] wr_line,
	input wire [1:0] wr_chunk,
	input wire [7:0] wr_be,
	input wire [63:0] wr_data,
	input wire clr_en,
	input wire clr_all,
	input wire [1:0] clr_chunk,
	output reg [35:5] line_r,
	output reg [31:0] valid_r,
	output reg [255:0] data_r,
	output wire occupied,
	output wire all_valid,
	output wire [1:0] next_chunk
);
	integer i;
	reg [31:0] valid_nxt;

	function [1:0] first_chunk;
		input [31:0] v;
		integer k;
		begin
			first_chunk = 2'h0;
			for (k = CHUNKS - 1; k >= 0; k = k - 1) begin
				if (v[k*8 +: 8] != `MTPU_CHUNK_NONE) begin
					first_chunk = k[1:0];
				end
			end
		end
	endfunction

	assign occupied = |valid_r;
	assign all_valid = (valid_r == `MTPU_BE_FULL);
	assign next_chunk = first_chunk(valid_r);

	always @* begin
		valid_nxt = valid_r;
		if (clr_en && clr_all) begin
			valid_nxt = 32'h00000000;
		end else if (clr_en) begin
			valid_nxt[{clr_chunk, 3'h0} +: 8] = `MTPU_CHUNK_NONE;
		end
		// A write in the clearing cycle keeps its bytes
		if (wr_en) begin
			valid_nxt[{wr_chunk, 3'h0} +: 8] = valid_nxt[{wr_chunk, 3'h0} +: 8] | wr_be;
		end
	end

	always @(posedge clock) begin
		if (!rst_b) begin
			valid_r <= 32'h00000000;
			line_r <= 31'h00000000;
			data_r <= 256'h0;
		end else begin
			valid_r <= valid_nxt;
			if (wr_en) begin
				line_r <= wr_line;
				for (i = 0; i < 8; i = i + 1) begin
					if (wr_be[i]) begin
						data_r[{wr_chunk, 6'h00} + i*8 +: 8] <= wr_data[i*8 +: 8];
					end
				end
			end
		end
	end
endmodule // mtpu_wcbuf

//--- mtpu_policy_unit.v
`timescale 1ns/1ps
`include "mtpu_defs.vh"

// Operation
// - Memory type goes out on the type pins in request clock two.
// - Uncached is 00; never cached, always on bus, never speculative.
// - Write-combining is 04; reads uncached, writes combine, speculative reads allowed.
// - Write-through is 05; reads cacheable, every write goes to memory.
// - Write-through writes never fill; they update or invalidate valid lines.
// - Write-protected is 06; reads hit and fill, writes bypass the cache.
// - Writeback is 07; write misses allocate, writes finish in the cache.
// - Storing any other type faults with code zero, register kept.
// - Uncached accesses run strictly in program order; others may pass.
// - Types forbidding speculation or reordering are also non-cacheable.
// - Combining buffer flushes on new line, interrupt exit, serializing, lock, I/O.
// - Combining buffers drain in any order relative to each other.
// - A fully valid buffer leaves as one 32-byte write, write flag set.
// - A partial buffer leaves as writes of at most eight bytes, any order.
// - Write-through writes may split at boundaries but are never combined.
// - Write-through updates valid L1 data, invalidates L2 and L1 code lines.
// - Write-protect only blocks cache updates; the write reaches memory.
// - Writeback may sit in any cache and stays processor ordered.
module mtpu_policy_unit (
	input wire clock,
	input wire rst_b,
	input wire type_wr_en,
	input wire [7:0] type_wr_data,
	output reg [7:0] range_type_register_r,
	output reg protection_fault_r,
	input wire cpu_req_valid,
	output wire cpu_req_ready,
	input wire cpu_write,
	input wire cpu_spec,
	input wire [35:3] cpu_addr,
	input wire [7:0] cpu_be,
	input wire [63:0] cpu_data,
	input wire flush_event,
	input wire l1d_hit,
	input wire l1c_hit,
	input wire l2_hit,
	output wire speculation_ok,
	output wire reorder_ok,
	output reg act_valid_r,
	output reg act_l1d_update_r,
	output reg act_l1d_inval_r,
	output reg act_l1c_inval_r,
	output reg act_l2_inval_r,
	output reg act_fill_r,
	output reg act_write_in_cache_r,
	output wire bus_ads,
	output reg [3:0] memory_type_pins_b_r,
	output reg [35:3] bus_addr_r,
	output reg [31:0] bus_be_r,
	output reg [255:0] bus_data_r,
	output reg write_direction_flag_r,
	output reg bus_line_r,
	input wire bus_done,
	output wire combining_busy
);
	// ****************************************
	// Type checks and policy decode
	// ****************************************
	function legal_type;
		input [7:0] t;
		begin
			legal_type = (t == `MTPU_UC) || (t == `MTPU_WC) || (t == `MTPU_WT) ||
				(t == `MTPU_WP) || (t == `MTPU_WB);
		end
	endfunction

	function read_cacheable;
		input [7:0] t;
		begin
			read_cacheable = (t == `MTPU_WT) || (t == `MTPU_WP) || (t == `MTPU_WB);
		end
	endfunction

	reg [1:0] state_r;
	reg [1:0] state_nxt;
	reg drain_r;
	reg drain_src_r;
	reg drain_all_r;
	reg [1:0] drain_chunk_r;
	reg [7:0] bus_type_r;

	wire [7:0] cur_type;
	wire is_uc;
	wire is_wc;
	wire is_wt;
	wire is_wp;
	wire is_wb;
	wire [35:5] wcb_line;
	wire [31:0] wcb_valid;
	wire [255:0] wcb_data;
	wire wcb_occupied;
	wire wcb_full;
	wire [1:0] wcb_next;
	wire idle;
	wire wc_write;
	wire line_conflict;
	wire spec_block;
	wire accept;
	wire any_hit;
	wire go_bus;
	wire start_drain;
	wire done_drain;

	assign cur_type = range_type_register_r;
	assign is_uc = (cur_type == `MTPU_UC);
	assign is_wc = (cur_type == `MTPU_WC);
	assign is_wt = (cur_type == `MTPU_WT);
	assign is_wp = (cur_type == `MTPU_WP);
	assign is_wb = (cur_type == `MTPU_WB);
	assign any_hit = l1d_hit | l1c_hit | l2_hit;

	// Uncached forbids speculation and reordering, hence never cacheable
	assign speculation_ok = !is_uc;
	assign reorder_ok = !is_uc;

	// ****************************************
	// Range type register
	// ****************************************
	always @(posedge clock) begin
		if (!rst_b) begin
			range_type_register_r <= `MTPU_RESET_TYPE;
			protection_fault_r <= 1'b0;
		end else begin
			protection_fault_r <= type_wr_en && !legal_type(type_wr_data);
			if (type_wr_en && legal_type(type_wr_data)) begin
				range_type_register_r <= type_wr_data;
			end
		end
	end

	// ****************************************
	// Request acceptance
	// ****************************************
	assign idle = (state_r == `MTPU_S_IDLE);
	assign wc_write = is_wc && cpu_write;
	assign line_conflict = wc_write && wcb_occupied && (wcb_line != cpu_addr[35:5]);
	assign spec_block = is_uc && cpu_spec;
	// Single issue behind an idle sequencer keeps uncached strictly in order;
	// the cost is no overlap between any two bus transactions.
	assign cpu_req_ready = idle && !drain_r && !flush_event && !spec_block &&
		!line_conflict;
	assign accept = cpu_req_valid && cpu_req_ready;
	assign combining_busy = wcb_occupied;

	// Bus needed: uncached, WC reads, cacheable read misses, WT/WP writes,
	// writeback write misses read the line for ownership.
	assign go_bus = accept && !wc_write && (is_uc || is_wc || !any_hit || (cpu_write &&
		(is_wt || is_wp)));

	assign start_drain = idle && drain_r && wcb_occupied;
	assign done_drain = (state_r == `MTPU_S_WAIT) && bus_done && drain_src_r;

	// ****************************************
	// Cache action pulses
	// ****************************************
	always @(posedge clock) begin
		if (!rst_b) begin
			act_valid_r <= 1'b0;
			act_l1d_update_r <= 1'b0;
			act_l1d_inval_r <= 1'b0;
			act_l1c_inval_r <= 1'b0;
			act_l2_inval_r <= 1'b0;
			act_fill_r <= 1'b0;
			act_write_in_cache_r <= 1'b0;
		end else begin
			act_valid_r <= accept;
			// WT writes refresh a valid L1 data line only
			act_l1d_update_r <= accept && cpu_write && is_wt && l1d_hit;
			// Uncached and WC hits are dropped from every cache
			act_l1d_inval_r <= accept && (is_uc || is_wc) && l1d_hit;
			act_l1c_inval_r <= accept && l1c_hit && (is_uc || is_wc ||
				(cpu_write && is_wt));
			act_l2_inval_r <= accept && l2_hit && (is_uc || is_wc ||
				(cpu_write && (is_wt || is_wp)));
			// Fills come from read misses, and WB write misses allocate
			act_fill_r <= accept && !any_hit && ((!cpu_write && read_cacheable(cur_type)) ||
				(cpu_write && is_wb));
			act_write_in_cache_r <= accept && cpu_write && is_wb;
		end
	end

	// ****************************************
	// Combining buffer and its drain
	// ****************************************
	mtpu_wcbuf #(
		.CHUNKS(`MTPU_CHUNKS)
	) u_wcbuf (
		.clock(clock),
		.rst_b(rst_b),
		.wr_en(accept && wc_write),
		.wr_line(cpu_addr[35:5]),
		.wr_chunk(cpu_addr[4:3]),
		.wr_be(cpu_be),
		.wr_data(cpu_data),
		.clr_en(done_drain),
		.clr_all(drain_all_r),
		.clr_chunk(drain_chunk_r),
		.line_r(wcb_line),
		.valid_r(wcb_valid),
		.data_r(wcb_data),
		.occupied(wcb_occupied),
		.all_valid(wcb_full),
		.next_chunk(wcb_next)
	);

	always @(posedge clock) begin
		if (!rst_b) begin
			drain_r <= 1'b0;
		end else if ((flush_event || (cpu_req_valid && line_conflict)) && wcb_occupied) begin
			drain_r <= 1'b1;
		end else if (idle && !wcb_occupied) begin
			drain_r <= 1'b0;
		end
	end

	// ****************************************
	// Bus request sequencer
	// ****************************************
	always @* begin
		state_nxt = state_r;
		case (state_r)
			`MTPU_S_IDLE: begin
				if (start_drain || go_bus) begin
					state_nxt = `MTPU_S_REQ1;
				end
			end
			`MTPU_S_REQ1: begin
				state_nxt = `MTPU_S_REQ2;
			end
			`MTPU_S_REQ2: begin
				state_nxt = `MTPU_S_WAIT;
			end
			`MTPU_S_WAIT: begin
				if (bus_done) begin
					state_nxt = `MTPU_S_IDLE;
				end
			end
			default: begin
				state_nxt = `MTPU_S_IDLE;
			end
		endcase
	end

	assign bus_ads = (state_r == `MTPU_S_REQ1);

	always @(posedge clock) begin
		if (!rst_b) begin
			state_r <= `MTPU_S_IDLE;
			memory_type_pins_b_r <= `MTPU_PINS_IDLE;
			bus_type_r <= `MTPU_RESET_TYPE;
			bus_addr_r <= 33'h000000000;
			bus_be_r <= 32'h00000000;
			bus_data_r <= 256'h0;
			write_direction_flag_r <= 1'b0;
			bus_line_r <= 1'b0;
			drain_src_r <= 1'b0;
			drain_all_r <= 1'b0;
			drain_chunk_r <= 2'h0;
		end else begin
			state_r <= state_nxt;
			// Pins carry the type only in the clock after the strobe
			if (state_nxt == `MTPU_S_REQ2) begin
				memory_type_pins_b_r <= ~bus_type_r[3:0];
			end else begin
				memory_type_pins_b_r <= `MTPU_PINS_IDLE;
			end
			if (start_drain) begin
				drain_src_r <= 1'b1;
				bus_type_r <= `MTPU_WC;
				write_direction_flag_r <= 1'b1;
				bus_data_r <= wcb_data;
				drain_chunk_r <= wcb_next;
				if (wcb_full) begin
					drain_all_r <= 1'b1;
					bus_line_r <= 1'b1;
					bus_addr_r <= {wcb_line, 2'h0};
					bus_be_r <= `MTPU_BE_FULL;
				end else begin
					// Lowest valid chunk first; order carries no meaning
					drain_all_r <= 1'b0;
					bus_line_r <= 1'b0;
					bus_addr_r <= {wcb_line, wcb_next};
					bus_be_r <= wcb_valid & ({24'h000000, 8'hFF} << {wcb_next, 3'h0});
				end
			end else if (go_bus) begin
				drain_src_r <= 1'b0;
				drain_all_r <= 1'b0;
				bus_type_r <= cur_type;
				// A writeback write miss fetches its line with a read for ownership
				write_direction_flag_r <= cpu_write && !is_wb;
				if (!cpu_write && read_cacheable(cur_type)) begin
					// Cacheable read miss fetches the whole line
					bus_line_r <= 1'b1;
					bus_addr_r <= {cpu_addr[35:5], 2'h0};
					bus_be_r <= `MTPU_BE_FULL;
				end else if (cpu_write && is_wb) begin
					bus_line_r <= 1'b1;
					bus_addr_r <= {cpu_addr[35:5], 2'h0};
					bus_be_r <= `MTPU_BE_FULL;
				end else begin
					// Each write leaves alone, as issued, never merged
					bus_line_r <= 1'b0;
					bus_addr_r <= cpu_addr;
					bus_be_r <= {24'h000000, cpu_be} << {cpu_addr[4:3], 3'h0};
				end
				bus_data_r <= {4{cpu_data}};
			end
		end
	end
endmodule // mtpu_policy_unit

//--- mtpu_policy_unit_monitor.sv
`timescale 1ns/1ps
// ****************************************
// Port checker
// ****************************************
module mtpu_policy_unit_monitor (
	input logic clock,
	input logic rst_b,
	input logic type_wr_en,
	input logic [7:0] type_wr_data,
	input logic [7:0] range_type_register_r,
	input logic protection_fault_r,
	input logic cpu_req_valid,
	input logic cpu_req_ready,
	input logic cpu_write,
	input logic cpu_spec,
	input logic flush_event,
	input logic speculation_ok,
	input logic act_valid_r,
	input logic act_l1d_update_r,
	input logic act_l2_inval_r,
	input logic act_fill_r,
	input logic act_write_in_cache_r,
	input logic l1d_hit,
	input logic l2_hit,
	input logic bus_ads,
	input logic [3:0] memory_type_pins_b_r,
	input logic [35:3] bus_addr_r,
	input logic [31:0] bus_be_r,
	input logic write_direction_flag_r,
	input logic bus_line_r
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_b);
	wire acc = cpu_req_valid && cpu_req_ready;
	wire [7:0] t = range_type_register_r;
	// Legal codes are 00 and 04..07
	wire lg = type_wr_data == 8'h00 || type_wr_data[7:2] == 6'h01;
	wire wr = acc && cpu_write;
	a_pins_req_two: assert property (bus_ads |=> memory_type_pins_b_r == ~t[3:0])
		else $error("type pins wrong in request clock two");
	a_pins_idle_high: assert property (!bus_ads |=> memory_type_pins_b_r == 4'hF)
		else $error("type pins driven outside request");
	a_bad_type_fault: assert property (type_wr_en && !lg |=> protection_fault_r && $stable(t))
		else $error("illegal type not refused");
	a_good_type_store: assert property (type_wr_en && lg |=> !protection_fault_r && t == $past(type_wr_data))
		else $error("legal type not stored");
	a_uc_no_spec: assert property (t == 8'h00 |-> !speculation_ok && !(cpu_spec && cpu_req_ready))
		else $error("speculation allowed on uncached");
	a_uc_on_bus: assert property (acc && t == 8'h00 |=> bus_ads && act_valid_r && !act_fill_r)
		else $error("uncached access not on bus");
	a_wt_write_path: assert property (wr && t == 8'h05 |=> bus_ads && !act_fill_r
		&& act_l1d_update_r == $past(l1d_hit) && act_l2_inval_r == $past(l2_hit))
		else $error("write-through write path wrong");
	a_wp_write_bypass: assert property (wr && t == 8'h06 |=> bus_ads && !act_fill_r && !act_l1d_update_r)
		else $error("write-protected write touched cache");
	a_wb_write_cache: assert property (wr && t == 8'h07 |-> ##1 act_write_in_cache_r)
		else $error("writeback write not done in cache");
	a_wc_write_held: assert property (wr && t == 8'h04 |=> !bus_ads)
		else $error("combining write went straight to bus");
	a_full_line_write: assert property (bus_ads && bus_line_r && write_direction_flag_r
		|-> bus_be_r == 32'hFFFFFFFF ##1 memory_type_pins_b_r == 4'hB)
		else $error("full buffer flush malformed");
	a_part_one_span: assert property (bus_ads && !bus_line_r
		|-> (bus_be_r & ~(32'hFF << {bus_addr_r[4:3], 3'h0})) == 32'h0)
		else $error("partial write spans more than eight bytes");
	a_flush_stall: assert property (flush_event |-> !cpu_req_ready)
		else $error("access taken during flush event");
	cover property (bus_ads && bus_line_r && write_direction_flag_r);
	cover property (bus_ads && !bus_line_r && t == 8'h04);
	cover property (protection_fault_r);
endmodule // mtpu_policy_unit_monitor

bind mtpu_policy_unit mtpu_policy_unit_monitor mon (.*);

//--- mtpu_bus_model.sv
`timescale 1ns/1ps
// ****************************************
// Far side memory agent
// ****************************************
module mtpu_bus_model (
	input logic clock,
	input logic rst_b,
	input logic bus_ads,
	input logic [3:0] lat,
	output logic bus_done
);
	logic [4:0] cnt_r;
	// Each strobe gets one bus_done after a delay set by lat; enables and data are not examined
	always @(posedge clock) begin
		if (!rst_b) begin
			cnt_r <= 5'h00;
			bus_done <= 1'b0;
		end else begin
			bus_done <= (cnt_r == 5'h02);
			if (bus_ads)
				cnt_r <= {1'b0, lat} + 5'h03;
			else if (cnt_r != 5'h00)
				cnt_r <= cnt_r - 5'h01;
		end
	end
endmodule // mtpu_bus_model

//--- memory_type_policy_unit_tb_top.sv
`timescale 1ns/1ps
module memory_type_policy_unit_tb_top;
	logic clock, rst_b, type_wr_en, cpu_req_valid, cpu_write, cpu_spec, flush_event;
	logic l1d_hit, l1c_hit, l2_hit, bus_done, protection_fault_r, cpu_req_ready;
	logic speculation_ok, reorder_ok, act_valid_r, act_l1d_update_r, act_l1d_inval_r;
	logic act_l1c_inval_r, act_l2_inval_r, act_fill_r, act_write_in_cache_r, bus_ads;
	logic write_direction_flag_r, bus_line_r, combining_busy;
	logic [7:0] type_wr_data, cpu_be, range_type_register_r;
	logic [35:3] cpu_addr, bus_addr_r;
	logic [63:0] cpu_data;
	logic [3:0] memory_type_pins_b_r, lat;
	logic [31:0] bus_be_r;
	logic [255:0] bus_data_r;
	logic [33:0] log[$];
	int errors = 0;
	int compares = 0;
	int cyc = 0;
	mtpu_policy_unit dut (.*);
	mtpu_bus_model far (.clock(clock), .rst_b(rst_b), .bus_ads(bus_ads), .lat(lat),
		.bus_done(bus_done));
	initial begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (bus_ads === 1'b1)
			log.push_back({bus_line_r, write_direction_flag_r, bus_be_r});
		if (cyc > 5000) begin
			errors++;
			finish_test;
		end
	end
	task chk(input logic [255:0] g, input logic [255:0] e);
		compares++;
		if (g !== e) begin
			errors++;
			$display("[FAIL] t=%0t got=%0h exp=%0h", $time, g, e);
		end
	endtask
	task setty(input logic [7:0] d);
		@(posedge clock);
		type_wr_en <= 1'b1;
		type_wr_data <= d;
		@(posedge clock);
		type_wr_en <= 1'b0;
		#1;
	endtask
	task acc(input logic w, input logic [35:3] a, input logic [7:0] be, input logic [2:0] h);
		@(posedge clock);
		cpu_req_valid <= 1'b1;
		cpu_write <= w;
		cpu_addr <= a;
		cpu_be <= be;
		{l1d_hit, l1c_hit, l2_hit} <= h;
		do @(posedge clock); while (cpu_req_ready !== 1'b1);
		cpu_req_valid <= 1'b0;
		#1;
	endtask
	task idle;
		@(posedge clock);
		while (cpu_req_ready !== 1'b1) @(posedge clock);
	endtask
	task pins(input logic [3:0] e);
		@(posedge clock);
		#1 chk(memory_type_pins_b_r, e);
		idle;
	endtask
	task t_types;
		logic [7:0] v[9] = '{8'h00, 8'h04, 8'h05, 8'h06, 8'h07, 8'h01, 8'h03, 8'h08, 8'hFF};
		logic [7:0] e = 8'h00;
		for (int i = 0; i < 9; i++) begin
			setty(v[i]);
			if (i < 5)
				e = v[i];
			chk(protection_fault_r, i >= 5);
			chk(range_type_register_r, e);
		end
	endtask
	task t_uc;
		setty(8'h00);
		@(posedge clock);
		cpu_spec <= 1'b1;
		@(posedge clock);
		#1 chk({cpu_req_ready, speculation_ok, reorder_ok}, 3'h0);
		@(posedge clock);
		cpu_spec <= 1'b0;
		acc(1'b0, 33'h10, 8'hFF, 3'h4);
		chk({bus_ads, act_fill_r, act_l1d_inval_r}, 3'h5);
		pins(4'hF);
	endtask
	task t_wt;
		setty(8'h05);
		acc(1'b1, 33'h21, 8'h0F, 3'h7);
		chk({act_l1d_update_r, act_l1c_inval_r, act_l2_inval_r, act_fill_r}, 4'hE);
		chk(bus_be_r, 32'h00000F00);
		chk(bus_addr_r, 33'h21);
		chk(bus_data_r, {4{64'h0123456789ABCDEF}});
		pins(4'hA);
		acc(1'b0, 33'h40, 8'hFF, 3'h0);
		chk({act_fill_r, bus_line_r}, 2'h3);
		idle;
	endtask
	task t_wp;
		setty(8'h06);
		acc(1'b1, 33'h42, 8'hF0, 3'h1);
		chk({bus_ads, act_l2_inval_r, act_l1d_update_r, act_fill_r}, 4'hC);
		pins(4'h9);
		acc(1'b0, 33'h48, 8'hFF, 3'h0);
		chk(act_fill_r, 1'b1);
		idle;
	endtask
	task t_wb;
		setty(8'h07);
		acc(1'b1, 33'h50, 8'hFF, 3'h4);
		chk({act_write_in_cache_r, bus_ads}, 2'h2);
		idle;
		acc(1'b1, 33'h58, 8'hFF, 3'h0);
		chk({act_fill_r, bus_line_r, write_direction_flag_r}, 3'h6);
		idle;
	endtask
	task flush;
		@(posedge clock);
		flush_event <= 1'b1;
		@(posedge clock);
		flush_event <= 1'b0;
		idle;
	endtask
	task t_wc;
		setty(8'h04);
		log.delete();
		for (int i = 0; i < 4; i++) begin
			acc(1'b1, {31'h100, i[1:0]}, 8'hFF, 3'h0);
			chk(bus_ads, 1'b0);
		end
		flush;
		chk(log.size(), 1);
		chk(log[0], {2'h3, 32'hFFFFFFFF});
		log.delete();
		lat <= 4'h6;
		acc(1'b1, {31'h200, 2'h2}, 8'h81, 3'h0);
		acc(1'b1, {31'h200, 2'h0}, 8'h3C, 3'h0);
		acc(1'b1, {31'h300, 2'h1}, 8'hFF, 3'h0);
		idle;
		chk(log.size(), 2);
		chk(log[0] | log[1], {2'h1, 32'h0081003C});
		flush;
		chk(log[2], {2'h1, 32'h0000FF00});
		chk(combining_busy, 1'b0);
	endtask
	task finish_test;
		if (errors == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		rst_b = 1'b0;
		type_wr_en = 1'b0;
		type_wr_data = 8'h00;
		cpu_req_valid = 1'b0;
		cpu_write = 1'b0;
		cpu_spec = 1'b0;
		cpu_addr = 33'h0;
		cpu_be = 8'h00;
		cpu_data = 64'h0123456789ABCDEF;
		flush_event = 1'b0;
		{l1d_hit, l1c_hit, l2_hit} = 3'h0;
		lat = 4'h0;
		repeat (6) @(posedge clock);
		rst_b <= 1'b1;
		t_types;
		t_uc;
		t_wt;
		t_wp;
		t_wb;
		t_wc;
		finish_test;
	end
endmodule // memory_type_policy_unit_tb_top
